// file: aod_pkg.sv
package aod_pkg;
  localparam int unsigned DATA_W = 8;
  localparam logic [DATA_W-1:0] CODE_FULL = 8'hff;
  localparam logic [DATA_W-1:0] CODE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] CODE_MID = 8'h80;
  localparam int unsigned DECIM_FIVE = 5;
  localparam int unsigned DECIM_TWO = 2;
  localparam int unsigned PIPE_DEPTH = 3;
  localparam int SAMPLE_MAX = 127;
  localparam int SAMPLE_MIN = -128;
  localparam int unsigned DIV5_HIGH = 2;
  localparam real CLK_MAX_MHZ = 250.0;
  localparam real SYS_CLK_MHZ = 25.0;
endpackage : aod_pkg

// file: aod_if.sv
`timescale 1ns/1ps
interface aod_if;
  logic [aod_pkg::DATA_W-1:0] primary_data_port;
  logic [aod_pkg::DATA_W-1:0] secondary_data_port;
  logic output_data_clock_p;
  logic output_data_clock_n;
  logic rate_divide_select;
  logic divide_five_select;
  logic mirror_select;
  modport dev (
    output primary_data_port, secondary_data_port, output_data_clock_p, output_data_clock_n,
    input rate_divide_select, divide_five_select, mirror_select
  );
  modport cap (
    input primary_data_port, secondary_data_port, output_data_clock_p, output_data_clock_n,
    output rate_divide_select, divide_five_select, mirror_select
  );
endinterface : aod_if

// file: aod_device.sv
`timescale 1ns/1ps
module aod_device #(
  parameter int unsigned PIPE_DEPTH = aod_pkg::PIPE_DEPTH, // conversion latency in clocks
  parameter int unsigned DIV_SLOW = aod_pkg::DECIM_FIVE, // slow decimation ratio
  parameter int unsigned DIV_FAST = aod_pkg::DECIM_TWO // demux ratio
) (
  input wire logic clk, // sample clock, true half
  input wire logic clk_n, // sample clock, complement half
  input wire logic rstn, // async reset, active low
  input wire logic signed [aod_pkg::DATA_W:0] sample_diff, // differential input, scaled codes
  aod_if.dev port // output ports and mode selects
);
  // ----------------------------------------------------------------
  // local types and constants
  // ----------------------------------------------------------------
  localparam int unsigned PHASE_W = $clog2(DIV_SLOW);
  typedef logic [aod_pkg::DATA_W-1:0] aod_code_t;
  typedef logic signed [aod_pkg::DATA_W:0] aod_diff_t;
  typedef logic [PHASE_W-1:0] aod_phase_t;
  localparam aod_diff_t DIFF_MAX = aod_diff_t'(aod_pkg::SAMPLE_MAX);
  localparam aod_diff_t DIFF_MIN = aod_diff_t'(aod_pkg::SAMPLE_MIN);
  localparam aod_phase_t PHASE_ZERO = '0;
  localparam aod_phase_t PHASE_STEP = aod_phase_t'(1);
  localparam aod_phase_t LAST_SLOW = aod_phase_t'(DIV_SLOW - 1);
  localparam aod_phase_t LAST_FAST = aod_phase_t'(DIV_FAST - 1);
  localparam aod_phase_t HIGH_SLOW = aod_phase_t'(aod_pkg::DIV5_HIGH);

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  aod_code_t code; // quantised level of the present input
  aod_code_t held_q; // level frozen at the falling clock
  aod_code_t pipe_q [PIPE_DEPTH]; // conversion latency stages
  aod_code_t newest; // sample leaving the pipeline
  aod_code_t prev_q; // sample one clock older
  aod_code_t a_q; // primary port register
  aod_code_t b_q; // secondary port register
  aod_code_t b_d; // next secondary value
  aod_phase_t phase_q; // position inside one output period
  aod_phase_t last_phase; // final phase of the selected ratio
  logic divided; // rate divide strapped on
  logic five; // divide by five strapped
  logic mirror; // secondary copies primary
  logic tick; // end of one output period
  logic update; // ports take a new sample this clock
  logic div_clk_d; // next divided clock level
  logic div_clk_q; // divided clock, rising-edge part
  logic half_q; // divided clock delayed half a cycle
  logic output_data_clock; // selected output clock

  // ----------------------------------------------------------------
  // quantiser and sampling
  // ----------------------------------------------------------------
  always_comb begin
    if (sample_diff > DIFF_MAX) begin
      code = aod_pkg::CODE_FULL;
    end else if (sample_diff < DIFF_MIN) begin
      code = aod_pkg::CODE_ZERO;
    end else begin
      // flipping the sign bit moves zero difference to midscale
      code = sample_diff[aod_pkg::DATA_W-1:0] ^ aod_pkg::CODE_MID;
    end
  end

  // falling edge freezes the sample, as the track/hold would
  always_ff @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      held_q <= aod_pkg::CODE_ZERO;
    end else begin
      held_q <= code;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pipe_q[0] <= aod_pkg::CODE_ZERO;
    end else begin
      pipe_q[0] <= held_q;
    end
  end

  for (genvar g = 1; g < PIPE_DEPTH; g++) begin : g_pipe
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        pipe_q[g] <= aod_pkg::CODE_ZERO;
      end else begin
        pipe_q[g] <= pipe_q[g-1];
      end
    end
  end

  assign newest = pipe_q[PIPE_DEPTH-1];

  // ----------------------------------------------------------------
  // output rate control
  // ----------------------------------------------------------------
  // selects are straps; changing them outside reset may give one odd period
  assign divided = port.rate_divide_select;
  assign five = port.divide_five_select;
  assign mirror = port.mirror_select;
  assign last_phase = five ? LAST_SLOW : LAST_FAST;
  assign tick = (phase_q == last_phase);
  assign update = !divided || tick;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= PHASE_ZERO;
    end else if (update) begin
      phase_q <= PHASE_ZERO;
    end else begin
      phase_q <= phase_q + PHASE_STEP;
    end
  end

  // duty set by phase counts, so in divide-by-two the input clock's duty cannot leak through
  always_comb begin
    if (five) begin
      div_clk_d = (phase_q < HIGH_SLOW);
    end else begin
      div_clk_d = (phase_q == PHASE_ZERO);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_clk_q <= 1'b0;
    end else begin
      div_clk_q <= div_clk_d;
    end
  end

  // the falling-edge copy adds the half cycle that makes 2.5 of 5
  always_ff @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      half_q <= 1'b0;
    end else begin
      half_q <= div_clk_q;
    end
  end

  // ----------------------------------------------------------------
  // port data, one update per output clock period
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= aod_pkg::CODE_ZERO;
    end else begin
      prev_q <= newest;
    end
  end

  // inactive secondary is held at zero so capture sees a stable level
  always_comb begin
    if (mirror) begin
      b_d = newest;
    end else if (divided && !five) begin
      b_d = prev_q;
    end else begin
      b_d = aod_pkg::CODE_ZERO;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_q <= aod_pkg::CODE_ZERO;
    end else if (update) begin
      a_q <= newest;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      b_q <= aod_pkg::CODE_ZERO;
    end else if (update) begin
      b_q <= b_d;
    end
  end

  assign port.primary_data_port = a_q;
  assign port.secondary_data_port = b_q;

  // ----------------------------------------------------------------
  // output data clock
  // ----------------------------------------------------------------
  // undivided mode must copy the input duty, so the clock passes through
  // ungated; that path and the divide-by-five path, which gates half_q with the inverted clk_n, are not taken from a flip-flop alone
  always_comb begin
    if (!divided) begin
      output_data_clock = clk;
    end else if (five) begin
      output_data_clock = div_clk_q | (half_q & ~clk_n);
    end else begin
      output_data_clock = div_clk_q;
    end
  end

  assign port.output_data_clock_p = output_data_clock;
  assign port.output_data_clock_n = ~output_data_clock;
endmodule : aod_device

// file: aod_capture.sv
`timescale 1ns/1ps
module aod_capture (
  input wire logic rstn, // async reset, active low
  input wire logic [2:0] mode_sel, // {rate divide, divide five, mirror}
  output logic [aod_pkg::DATA_W-1:0] primary_word, // captured primary port
  output logic [aod_pkg::DATA_W-1:0] secondary_word, // captured secondary port
  output logic word_toggle, // flips on every capture
  aod_if.cap port // device side
);
  // static straps only; no retiming needed
  assign port.rate_divide_select = mode_sel[2];
  assign port.divide_five_select = mode_sel[1];
  assign port.mirror_select = mode_sel[0];

  // capture on the falling output clock: mid data eye when undivided, but in divide-by-two that edge falls as the ports update
  always_ff @(negedge port.output_data_clock_p or negedge rstn) begin
    if (!rstn) begin
      primary_word <= aod_pkg::CODE_ZERO;
      secondary_word <= aod_pkg::CODE_ZERO;
      word_toggle <= 1'b0;
    end else begin
      primary_word <= port.primary_data_port;
      secondary_word <= port.secondary_data_port;
      word_toggle <= ~word_toggle;
    end
  end
endmodule : aod_capture

// file: aod_checker.sv
`timescale 1ns/1ps
module aod_checker (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic [aod_pkg::DATA_W-1:0] primary_data_port, // port a
  input wire logic [aod_pkg::DATA_W-1:0] secondary_data_port, // port b
  input wire logic output_data_clock_p, // output_data_clock
  input wire logic output_data_clock_n, // output_data_clock bar
  input wire logic rate_divide_select, // div
  input wire logic divide_five_select, // five
  input wire logic mirror_select // mirror
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic dv2 = rate_divide_select && !divide_five_select;
  wire logic dv5 = rate_divide_select && divide_five_select;
  sequence s_hold4; $stable(primary_data_port)[*4]; endsequence
  property p_diff; output_data_clock_n == !output_data_clock_p; endproperty
  property p_mir; mirror_select |-> secondary_data_port == primary_data_port; endproperty
  property p_idle;
    !mirror_select && (!rate_divide_select || divide_five_select) |-> secondary_data_port == 8'h00;
  endproperty
  property p_tog2;
    dv2 && $past(rstn) |-> output_data_clock_p != $past(output_data_clock_p);
  endproperty
  property p_half_a; dv2 && $changed(primary_data_port) |=> $stable(primary_data_port); endproperty
  property p_half_b;
    dv2 && $changed(secondary_data_port) |=> $stable(secondary_data_port);
  endproperty
  property p_five; dv5 && $changed(primary_data_port) |=> s_hold4; endproperty
  property p_dclk5;
    dv5 && $rose(output_data_clock_p) |=> (!$rose(output_data_clock_p))[*4];
  endproperty
  a_diff: assert property (p_diff) else $error("clock pair not complementary");
  a_mir: assert property (p_mir) else $error("mirror ports differ");
  a_idle: assert property (p_idle) else $error("inactive port not zero");
  a_tog2: assert property (p_tog2) else $error("half rate clock stuck");
  a_half_a: assert property (p_half_a) else $error("port a too fast");
  a_half_b: assert property (p_half_b) else $error("port b too fast");
  a_five: assert property (p_five) else $error("fifth sample rule broken");
  a_dclk5: assert property (p_dclk5) else $error("fifth rate clock wrong");
endmodule : aod_checker

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, rstn, tg, ltg;
  logic [2:0] mode;
  logic signed [8:0] diff;
  logic [7:0] pw, sw, lp, ls;
  logic [7:0] h [0:7];
  int err_count, checks_done, seed, m, i, cyc;
  aod_if bus ();
  aod_device u_aod_device (.clk(clk), .clk_n(~clk), .rstn(rstn), .sample_diff(diff), .port(bus));
  aod_capture u_aod_capture (.rstn(rstn), .mode_sel(mode), .primary_word(pw),
    .secondary_word(sw), .word_toggle(tg), .port(bus));
  aod_checker u_aod_checker (.clk(clk), .rstn(rstn), .primary_data_port(bus.primary_data_port),
    .secondary_data_port(bus.secondary_data_port), .output_data_clock_p(bus.output_data_clock_p),
    .output_data_clock_n(bus.output_data_clock_n), .rate_divide_select(bus.rate_divide_select),
    .divide_five_select(bus.divide_five_select), .mirror_select(bus.mirror_select));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] code(input int d);
    return d > 127 ? 8'hff : d < -128 ? 8'h00 : 8'(d + 128);
  endfunction : code
  task automatic summarize();
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // held sample taken at the falling edge
  always @(negedge clk) begin
    for (int k = 7; k > 0; k--) h[k] = h[k-1];
    h[0] = code(diff);
  end
  // divided modes checked only when a port moves, since the tick phase is free
  always @(posedge clk) begin
    #1;
    cyc = rstn ? cyc + 1 : 0;
    if (cyc > 8) begin
      if (!mode[2] || bus.primary_data_port !== lp || bus.secondary_data_port !== ls) begin
        chk(bus.primary_data_port, h[aod_pkg::PIPE_DEPTH]);
        if (mode == 3'h4) chk(bus.secondary_data_port, h[aod_pkg::PIPE_DEPTH+1]);
      end
      if (!mode[2] && tg !== ltg) chk(pw, lp);
      if (!mode[2] && tg !== ltg) chk(sw, ls);
    end
    lp = bus.primary_data_port;
    ls = bus.secondary_data_port;
    ltg = tg;
  end
  initial begin
    rstn = 0;
    mode = 0;
    diff = 0;
    err_count = 0;
    checks_done = 0;
    seed = 94951;
    for (m = 0; m < 8; m++) begin
      @(posedge clk);
      rstn <= 0;
      mode <= 3'(m);
      repeat (6) @(posedge clk);
      rstn <= 1;
      for (i = 0; i < 60; i++) begin
        @(posedge clk);
        diff <= (i % 9 == 0) ? 9'sh000 : 9'($random(seed));
      end
    end
    summarize();
  end
endmodule : testbench
